// >>> bench/dps_dev_model.sv
// Semaphore device model: host on the left port, bench on the right
module dps_dev_model (
	input  wire logic        clk,
	input  wire logic        sem_n,
	input  wire logic        oe_n,
	input  wire logic        rnw,
	input  wire logic [14:0] addr,
	input  wire logic [15:0] din,
	output logic      [15:0] dq,
	input  wire logic        r_sem_n,
	input  wire logic        r_rnw,
	input  wire logic [2:0]  r_idx,
	input  wire logic        r_d,
	output logic             r_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	// Power-up leaves the host side holding every token until it clears them
	logic [7:0] req_l = 8'h00;
	logic [7:0] req_r = 8'hff;
	logic [1:0] own [8] = '{default: 2'h1};
	logic ps = 1, pr = 1, po = 1, pd = 1, lat = 0;
	logic [2:0] pa = 0;
	// Both sides funnel through one update, so a tie is resolved by order
	task automatic wr(input logic [1:0] s, input logic [2:0] i, input logic v);
		if (s == 2'h1) req_l[i] = v;
		else req_r[i] = v;
		if (own[i] == s && v) own[i] = (s == 2'h1 ? !req_r[i] : !req_l[i]) ? 2'h3 - s : 2'h0;
		else if (own[i] == 2'h0 && !v) own[i] = s;
	endtask
	// Host write ends when select rises; read value latched on entry
	always @(posedge clk) begin
		if (sem_n && !ps && !pr) wr(2'h1, pa, pd);
		if (!sem_n && !oe_n && (ps || po)) lat <= own[addr[2:0]] != 2'h1;
		ps <= sem_n;
		pr <= rnw;
		po <= oe_n;
		pa <= addr[2:0];
		pd <= din[0];
	end
	always @(posedge r_sem_n) if (!r_rnw) wr(2'h2, r_idx, r_d);
	// Released bus shows the inverse so stale data cannot pass
	assign dq     = (!sem_n && !oe_n) ? {16{lat}} : {16{!lat}};
	assign r_flag = own[r_idx] != 2'h2;
endmodule // dps_dev_model

// >>> bench/dps_host_props.sv
// Port checker for the host-side semaphore controller
module dps_host_props #(
	parameter int unsigned ACCESS_CYCLES = 7
) (
	input wire logic                        clk,
	input wire logic                        resetn,
	input wire logic                        cmd_valid,
	input wire logic                        cmd_ready,
	input wire logic [1:0]                  cmd_op,
	input wire logic                        rsp_valid,
	input wire logic                        init_done,
	input wire logic [dps_pkg::ADDR_W-1:0]  addr,
	input wire logic                        mem_select_n,
	input wire logic                        semaphore_select_n,
	input wire logic                        output_enable_n,
	input wire logic                        read_not_write,
	input wire logic [dps_pkg::DATA_W-1:0]  data_out,
	input wire logic                        data_oe
);
	localparam int TAKE_LAT = 2 * ACCESS_CYCLES + 5;
	localparam int SHORT_LAT = ACCESS_CYCLES + 3;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	wire logic acc = cmd_valid && cmd_ready;
	// Strobe and bus relations
	mem_idle_a: assert property (mem_select_n) else $error("memory select active");
	read_strobe_a: assert property (!output_enable_n |-> !semaphore_select_n && read_not_write)
		else $error("read strobes wrong");
	addr_high_a: assert property (!semaphore_select_n |-> addr[14:3] == 12'h000)
		else $error("upper address set");
	write_bus_a: assert property (!read_not_write |-> data_oe && data_out == {16{data_out[0]}})
		else $error("write data not uniform");
	read_gap_a: assert property ($rose(output_enable_n) |-> output_enable_n [*2])
		else $error("no gap between reads");
	take_first_a: assert property (acc && cmd_op == dps_pkg::OP_TAKE |=> !read_not_write)
		else $error("take did not write first");
	take_lat_a: assert property (acc && cmd_op == dps_pkg::OP_TAKE |-> ##TAKE_LAT rsp_valid)
		else $error("take answer late");
	short_lat_a: assert property (
		acc && cmd_op != dps_pkg::OP_TAKE |-> ##SHORT_LAT rsp_valid)
		else $error("write or poll answer late");
	release_one_a: assert property (acc && cmd_op == dps_pkg::OP_RELEASE |=> data_out[0])
		else $error("release wrote zero");
	init_ones_a: assert property (!init_done && !read_not_write |-> data_out[0])
		else $error("init wrote zero");
endmodule // dps_host_props
bind dps_host dps_host_props #(.ACCESS_CYCLES(ACCESS_CYCLES)) u_props (.*);

// >>> bench/tb.sv
// Testbench for the host-side semaphore controller
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, resetn = 0, cmd_valid = 0, r_sem_n = 1, r_rnw = 1, r_d = 1;
	logic [1:0] cmd_op = 0;
	logic [2:0] cmd_index = 0, r_idx = 0;
	wire logic cmd_ready, rsp_valid, rsp_owned, rsp_consistent, init_done, r_flag;
	wire logic mem_select_n, semaphore_select_n, output_enable_n, read_not_write, data_oe;
	wire logic [14:0] addr;
	wire logic [15:0] data_out, data_in;
	int num_errors = 0, cmp_count = 0;
	dps_host u_dut (.*);
	dps_dev_model u_dev (.clk(clk), .sem_n(semaphore_select_n), .oe_n(output_enable_n),
		.rnw(read_not_write), .addr(addr), .din(data_out), .dq(data_in), .r_sem_n(r_sem_n),
		.r_rnw(r_rnw), .r_idx(r_idx), .r_d(r_d), .r_flag(r_flag));
	initial forever #4 clk = ~clk;
	task automatic chk(input logic got, input logic exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask
	// One command, held until taken, then judged on the answer pulse
	task automatic cmd(input logic [1:0] op, input logic [2:0] idx, input logic own);
		int n = 0;
		@(negedge clk);
		cmd_valid = 1;
		cmd_op = op;
		cmd_index = idx;
		// Ready is judged at the falling edge, where it has settled
		while (cmd_ready !== 1'b1 && n++ < 200) @(negedge clk);
		@(negedge clk);
		cmd_valid = 0;
		n = 0;
		while (rsp_valid !== 1'b1 && n++ < 40) @(negedge clk);
		chk(rsp_valid, 1, "no answer");
		chk(rsp_owned, own, "owner");
		chk(rsp_consistent, 1, "read data mixed");
	endtask
	// Right-side write; rnw is held around the select pulse
	task automatic rw(input logic [2:0] idx, input logic v);
		@(negedge clk);
		r_idx = idx;
		r_rnw = 0;
		r_d = v;
		@(negedge clk) r_sem_n = 0;
		@(negedge clk) r_sem_n = 1;
		@(negedge clk) r_rnw = 1;
	endtask
	task automatic t_init;
		for (int i = 0; i < 8; i++) begin
			rw(i, 1);
			cmd(dps_pkg::OP_POLL, i, 0);
		end
		chk(init_done, 1, "start-up sweep not finished");
		$display("test init done");
	endtask
	task automatic t_take;
		for (int i = 0; i < 8; i++) begin
			cmd(dps_pkg::OP_TAKE, i, 1);
			chk(r_flag, 1, "other side sees token");
			cmd(dps_pkg::OP_RELEASE, i, 0);
			chk(r_flag, 1, "flag not free");
		end
		$display("test take done");
	endtask
	task automatic t_pass;
		cmd(dps_pkg::OP_TAKE, 5, 1);
		rw(5, 0);
		chk(r_flag, 1, "right took owned token");
		cmd(dps_pkg::OP_POLL, 5, 1);
		cmd(dps_pkg::OP_RELEASE, 5, 0);
		chk(r_flag, 0, "token not handed over");
		cmd(dps_pkg::OP_TAKE, 5, 0);
		cmd(dps_pkg::OP_POLL, 5, 0);
		rw(5, 1);
		cmd(dps_pkg::OP_POLL, 5, 1);
		cmd(dps_pkg::OP_INIT, 5, 0);
		chk(r_flag, 1, "flag not freed");
		$display("test pass done");
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Whole run is near 600 cycles; the limit leaves ample margin
	initial begin
		#50us;
		num_errors++;
		$display("mismatch at %0t: watchdog", $time);
		stop_test;
	end
	initial begin
		repeat (10) @(negedge clk);
		chk(cmd_ready, 0, "ready during reset");
		resetn = 1;
		t_init;
		t_take;
		t_pass;
		stop_test;
	end
endmodule // tb

// >>> hw/dps_host.sv
// Host-side controller driving one port of a dual-port semaphore unit
module dps_host #(
	parameter int unsigned ACCESS_CYCLES = dps_pkg::ACCESS_CYC
) (
	input  wire logic                        clk,
	input  wire logic                        resetn,
	input  wire logic                        cmd_valid,
	output logic                             cmd_ready,
	input  wire logic [1:0]                  cmd_op,
	input  wire logic [dps_pkg::IDX_W-1:0]   cmd_index,
	output logic                             rsp_valid,
	output logic                             rsp_owned,
	output logic                             rsp_consistent,
	output logic                             init_done,
	output logic [dps_pkg::ADDR_W-1:0]       addr,
	output logic                             mem_select_n,
	output logic                             semaphore_select_n,
	output logic                             output_enable_n,
	output logic                             read_not_write,
	output logic [dps_pkg::DATA_W-1:0]       data_out,
	output logic                             data_oe,
	input  wire logic [dps_pkg::DATA_W-1:0]  data_in
);
	// Elaboration checks. The read value crosses two sync flops, so a
	// window under four cycles would judge stale pin data
	if (ACCESS_CYCLES < 4) begin : g_short_access
		$error("ACCESS_CYCLES below four");
	end
	// Phase counter must reach the last access and recovery cycle
	if (ACCESS_CYCLES > (1 << dps_pkg::CNT_W)
		|| dps_pkg::RECOVER_CYC < 1
		|| dps_pkg::RECOVER_CYC > (1 << dps_pkg::CNT_W)) begin : g_bad_count
		$error("phase counts do not fit the counter");
	end
	// Flag index must cover exactly the token count and fit the address
	if (dps_pkg::NUM_FLAGS != (1 << dps_pkg::IDX_W)
		|| dps_pkg::ADDR_W < dps_pkg::IDX_W) begin : g_bad_index
		$error("flag index does not match token count");
	end

	dps_pkg::dps_state_e state_r, state_nxt;
	logic [dps_pkg::CNT_W-1:0]  cnt_r, cnt_nxt;
	logic [1:0]                 op_r, op_nxt;
	logic [dps_pkg::IDX_W-1:0]  idx_r, idx_nxt;
	logic                       wval_r, wval_nxt;
	logic                       owned_r, owned_nxt, cons_r, cons_nxt;
	logic                       init_r, init_nxt;
	logic [dps_pkg::DATA_W-1:0] din_s;
	logic                       cnt_end, all_zero, all_one, last_idx;
	logic                       rec_end, wr_phase, rd_phase, boot_wr;

	// Pin data crosses from the device, so synchronise before use; the
	// word is stable because the device latches it for the whole read
	dps_sync #(.WIDTH(dps_pkg::DATA_W)) u_sync (
		.clk    (clk),
		.resetn (resetn),
		.d      (data_in),
		.q      (din_s)
	);

	assign cnt_end  = (cnt_r == dps_pkg::CNT_W'(ACCESS_CYCLES - 1));
	assign all_zero = (din_s == '0);
	assign all_one  = (din_s == '1);
	assign last_idx = (idx_r == dps_pkg::IDX_W'(dps_pkg::NUM_FLAGS - 1));
	// Recovery gap length is fixed; the same end test serves both gaps
	assign rec_end  = (cnt_r == dps_pkg::CNT_W'(dps_pkg::RECOVER_CYC - 1));
	// Sweep only at start-up; a user write-one is a single access, else
	// it would run on through the upper flags and never answer
	assign boot_wr  = (op_r == dps_pkg::OP_INIT) && !init_r;
	// Phase decode shared by select, direction and bus drive
	assign wr_phase = (state_r == dps_pkg::ST_WRITE);
	assign rd_phase = (state_r == dps_pkg::ST_READ);

	// Pins follow the state; memory select never asserted here
	assign mem_select_n       = 1'b1;
	assign semaphore_select_n = !(wr_phase || rd_phase);
	assign output_enable_n    = !rd_phase;
	assign read_not_write     = !wr_phase;
	assign data_oe            = wr_phase;
	assign addr               = {{(dps_pkg::ADDR_W - dps_pkg::IDX_W){1'b0}}, idx_r};
	assign cmd_ready          = (state_r == dps_pkg::ST_IDLE) && init_r;
	assign rsp_valid          = (state_r == dps_pkg::ST_DONE);
	assign rsp_owned          = owned_r;
	assign rsp_consistent     = cons_r;
	assign init_done          = init_r;

	// Only bit zero matters; other bits mirror it for clean bus levels
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			data_out <= '0;
		else
			data_out <= {dps_pkg::DATA_W{wval_nxt}};
	end

	// Sequencer: optional write phase and recovery, then optional read phase and recovery
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		op_nxt    = op_r;
		idx_nxt   = idx_r;
		wval_nxt  = wval_r;
		owned_nxt = owned_r;
		cons_nxt  = cons_r;
		init_nxt  = init_r;
		case (state_r)
		dps_pkg::ST_IDLE: begin
			cnt_nxt = '0;
			// Nothing is accepted until every flag has been written one
			if (!init_r) begin
				op_nxt    = dps_pkg::OP_INIT;
				wval_nxt  = 1'b1;
				state_nxt = dps_pkg::ST_WRITE;
			end else if (cmd_valid) begin
				op_nxt  = cmd_op;
				idx_nxt = cmd_index;
				wval_nxt = (cmd_op != dps_pkg::OP_TAKE);
				// Take always writes before reading back
				state_nxt = (cmd_op == dps_pkg::OP_POLL) ?
					dps_pkg::ST_READ : dps_pkg::ST_WRITE;
			end
		end
		dps_pkg::ST_WRITE: begin
			cnt_nxt = cnt_r + 1'b1;
			if (cnt_end) begin
				cnt_nxt   = '0;
				state_nxt = dps_pkg::ST_WREC;
			end
		end
		dps_pkg::ST_WREC: begin
			cnt_nxt = cnt_r + 1'b1;
			if (rec_end) begin
				cnt_nxt = '0;
				// Sweep steps through every flag; a plain write ends with an answer
				if (boot_wr) begin
					idx_nxt   = idx_r + 1'b1;
					state_nxt = last_idx ? dps_pkg::ST_IDLE : dps_pkg::ST_WRITE;
					init_nxt  = last_idx;
				end else if (op_r == dps_pkg::OP_TAKE)
					state_nxt = dps_pkg::ST_READ;
				else begin
					owned_nxt = 1'b0;
					cons_nxt  = 1'b1;
					state_nxt = dps_pkg::ST_DONE;
				end
			end
		end
		dps_pkg::ST_READ: begin
			cnt_nxt = cnt_r + 1'b1;
			if (cnt_end) begin
				// Zero means this side holds the token; one means
				// not owned, a request may still be pending
				cnt_nxt   = '0;
				owned_nxt = all_zero;
				cons_nxt  = all_zero || all_one;
				state_nxt = dps_pkg::ST_RREC;
			end
		end
		dps_pkg::ST_RREC: begin
			// Select and enable both drop so the next read relatches
			cnt_nxt = cnt_r + 1'b1;
			if (rec_end) begin
				cnt_nxt   = '0;
				state_nxt = dps_pkg::ST_DONE;
			end
		end
		dps_pkg::ST_DONE: begin
			// Failed take leaves request pending; caller polls or releases
			state_nxt = dps_pkg::ST_IDLE;
		end
		default: state_nxt = dps_pkg::ST_IDLE;
		endcase
	end

	// State registers; reset leaves the start-up sweep still owed, so no
	// command is taken before the flags are cleared
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= dps_pkg::ST_IDLE;
			cnt_r   <= '0;
			op_r    <= dps_pkg::OP_INIT;
			idx_r   <= '0;
			wval_r  <= 1'b1;
			owned_r <= 1'b0;
			cons_r  <= 1'b0;
			init_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			op_r    <= op_nxt;
			idx_r   <= idx_nxt;
			wval_r  <= wval_nxt;
			owned_r <= owned_nxt;
			cons_r  <= cons_nxt;
			init_r  <= init_nxt;
		end
	end
	// Arbitration and token transfer live in the device; this side
	// only sees them through the read-back value
endmodule : dps_host

// >>> hw/dps_pkg.sv
// Package: constants for the host-side semaphore port controller
package dps_pkg;
	localparam int unsigned NUM_FLAGS      = 8;    // Token latches in the device
	localparam int unsigned IDX_W          = 3;    // Index bits used in semaphore space
	localparam int unsigned ADDR_W         = 15;   // Device address width
	localparam int unsigned DATA_W         = 16;   // Device data width
	localparam int unsigned CLK_PERIOD_NS  = 8;    // 125 MHz
	localparam int unsigned ACCESS_NS      = 55;   // Slowest access window allowed for
	localparam int unsigned ACCESS_CYC     = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RECOVER_CYC    = 2;    // Strobes inactive between accesses
	localparam int unsigned CNT_W          = 8;
	localparam logic [1:0]  OP_TAKE        = 2'h0; // Write 0 then read back
	localparam logic [1:0]  OP_RELEASE     = 2'h1; // Write 1
	localparam logic [1:0]  OP_POLL        = 2'h2; // Read only
	localparam logic [1:0]  OP_INIT        = 2'h3; // Write 1 to every flag at start-up, to one flag after

	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_WRITE = 6'h02,
		ST_WREC  = 6'h04,
		ST_READ  = 6'h08,
		ST_RREC  = 6'h10,
		ST_DONE  = 6'h20
	} dps_state_e;
endpackage : dps_pkg

// >>> hw/dps_sync.sv
// Two-flop synchroniser for pin inputs
module dps_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;

	// First stage feeds only the second
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : dps_sync
